// ---- logic/dcwu_params.svh ----
// constants of the debug command and watchpoint unit
`ifndef DCWU_PARAMS_SVH
`define DCWU_PARAMS_SVH
// host command bytes
`define DCWU_CMD_REV 8'h00
`define DCWU_CMD_RSVD 8'h01
`define DCWU_CMD_STAT 8'h02
`define DCWU_CMD_CNT 8'h03
`define DCWU_CMD_WCTL 8'h04
`define DCWU_CMD_RCTL 8'h05
`define DCWU_CMD_WPC 8'h06
`define DCWU_CMD_RPC 8'h07
`define DCWU_CMD_WREG 8'h08
`define DCWU_CMD_RREG 8'h09
// apb byte offsets
`define DCWU_OFF_WCTL 8'h00
`define DCWU_OFF_WADDR 8'h04
`define DCWU_OFF_WDATA 8'h08
`define DCWU_OFF_CTL 8'h0C
`define DCWU_OFF_STAT 8'h10
`define DCWU_OFF_CNT 8'h14
`define DCWU_OFF_IST 8'h18
`define DCWU_OFF_IMSK 8'h1C
// watch control fields
`define DCWU_WCTL_WR 7
`define DCWU_WCTL_RD 6
`define DCWU_WCTL_DM 5
`define DCWU_WCTL_RSVD 4
`define DCWU_WCTL_AHI 3:0
`define DCWU_WCTL_RST 8'h00
// debug control and status fields
`define DCWU_CTL_DBG 7
`define DCWU_STAT_DBG 7
`define DCWU_STAT_RP 0
`define DCWU_RP_ON 1'b0
// runtime counter
`define DCWU_CNT_MAX 16'hFFFF
`define DCWU_CNT_ONE 16'h0001
// flash control register window
`define DCWU_FLASH_CTL 12'hFF8
`define DCWU_FLASH_HI 12'hFFB
// interrupt events
`define DCWU_EV_W 3
`define DCWU_EV_WATCH 0
`define DCWU_EV_REFUSE 1
`define DCWU_EV_FULL 2
`endif

// ---- logic/dcwu_pkg.sv ----
// types of the debug command and watchpoint unit
package dcwu_pkg;
   typedef enum logic [1:0] {op_wr_pc, op_rd_pc, op_wr_reg, op_rd_reg} dcwu_op_t;
   typedef struct packed {
      logic valid;
      logic [7:0] code;
      logic [15:0] arg;
      logic [7:0] data;
   } dcwu_cmd_t;
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } dcwu_resp_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [7:0] data;
   } dcwu_rf_access_t;
   typedef struct packed {
      logic valid;
      dcwu_op_t op;
      logic [15:0] addr;
      logic [7:0] data;
   } dcwu_core_req_t;
endpackage : dcwu_pkg

// ---- logic/dcwu_top.sv ----
// debug command gate, runtime counter and register-file watchpoint
`timescale 1ns/1ns
`include "dcwu_params.svh"
module dcwu_top #(
   parameter logic [7:0] REVISION = 8'h01,
   parameter logic [7:0] MASS_ERASE_CODE = 8'h00
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // host commands
   input dcwu_pkg::dcwu_cmd_t cmd,
   output dcwu_pkg::dcwu_resp_t resp,
   output logic cmd_refused,
   // processor side
   input dcwu_pkg::dcwu_rf_access_t rf_acc,
   input dcwu_pkg::dcwu_resp_t core_ans,
   output dcwu_pkg::dcwu_core_req_t core_req,
   // option pin
   input wire logic read_protect_option,
   // status
   output logic debug_mode_flag,
   output logic read_protect_active,
   output logic irq
);
   // revision value is arbitrary

   logic [2:0] rp_sync;
   logic [7:0] watch_control_address_high;
   logic [7:0] watch_address_lo;
   logic [7:0] watch_data;
   logic [6:0] ctl_low;
   logic [15:0] runtime_cnt;
   logic dm_q;
   logic [`DCWU_EV_W-1:0] irq_status;
   logic [`DCWU_EV_W-1:0] irq_mask;
   logic [`DCWU_EV_W-1:0] ev;
   logic [`DCWU_EV_W-1:0] w1c;
   logic cmd_ok;
   logic watch_hit;
   logic cnt_exit;
   logic cnt_run;
   logic apb_setup;
   logic apb_wr;
   logic [7:0] debug_control_reg;
   logic [7:0] status_byte;
   logic [11:0] watch_address;

   function automatic logic in_flash(input logic [11:0] a);
      in_flash = (a >= `DCWU_FLASH_CTL) && (a <= `DCWU_FLASH_HI);
   endfunction : in_flash

   function automatic logic cmd_allowed(input logic [7:0] c, input logic d, input logic p,
                                        input logic [11:0] a, input logic [7:0] v);
      unique case (c)
         `DCWU_CMD_REV, `DCWU_CMD_STAT, `DCWU_CMD_WCTL, `DCWU_CMD_RCTL: cmd_allowed = 1'b1;
         `DCWU_CMD_CNT: cmd_allowed = d;
         `DCWU_CMD_WPC, `DCWU_CMD_RPC, `DCWU_CMD_RREG: cmd_allowed = d && !p;
         `DCWU_CMD_WREG: cmd_allowed = d && (!p || (in_flash(a) && (a != `DCWU_FLASH_CTL || v == MASS_ERASE_CODE)));
         default: cmd_allowed = 1'b0;
      endcase
   endfunction : cmd_allowed

   assign watch_address = {watch_control_address_high[`DCWU_WCTL_AHI], watch_address_lo};
   assign debug_control_reg = {debug_mode_flag, ctl_low};
   assign status_byte = {debug_mode_flag, 6'h00, read_protect_active};
   assign cmd_ok = cmd.valid && cmd_allowed(cmd.code, debug_mode_flag, read_protect_active,
                                            cmd.arg[11:0], cmd.data);
   assign watch_hit = (rf_acc.addr == watch_address)
      && ((rf_acc.wr && watch_control_address_high[`DCWU_WCTL_WR])
          || (rf_acc.rd && watch_control_address_high[`DCWU_WCTL_RD]))
      && (!watch_control_address_high[`DCWU_WCTL_DM] || rf_acc.data == watch_data);
   assign cnt_exit = !debug_mode_flag && dm_q;
   assign cnt_run = !debug_mode_flag && !dm_q && runtime_cnt != `DCWU_CNT_MAX;
   assign ev[`DCWU_EV_WATCH] = watch_hit;
   assign ev[`DCWU_EV_REFUSE] = cmd.valid && !cmd_ok;
   assign ev[`DCWU_EV_FULL] = cnt_run && runtime_cnt == `DCWU_CNT_MAX - `DCWU_CNT_ONE;
   assign apb_setup = psel && !penable;
   assign apb_wr = psel && penable && pready && pwrite && !pslverr;
   assign w1c = (apb_wr && paddr == `DCWU_OFF_IST) ? pwdata[`DCWU_EV_W-1:0] : '0;

   // option pin synchroniser, protected until settled
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rp_sync <= 3'h0;
      end else begin
         rp_sync <= {rp_sync[1:0], read_protect_option};
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         read_protect_active <= 1'b1;
      end else if (rp_sync[2] == rp_sync[1]) begin
         read_protect_active <= (rp_sync[2] == `DCWU_RP_ON);
      end
   end

   // debug mode flag
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         debug_mode_flag <= 1'b0;
      end else if (watch_hit) begin
         debug_mode_flag <= 1'b1;
      end else if (cmd_ok && cmd.code == `DCWU_CMD_WCTL) begin
         debug_mode_flag <= cmd.data[`DCWU_CTL_DBG] || (read_protect_active && debug_mode_flag);
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctl_low <= 7'h00;
      end else if (cmd_ok && cmd.code == `DCWU_CMD_WCTL) begin
         ctl_low <= cmd.data[6:0];
      end
   end

   // runtime counter
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dm_q <= 1'b0;
         runtime_cnt <= 16'h0000;
      end else begin
         dm_q <= debug_mode_flag;
         if (cnt_exit) begin
            runtime_cnt <= 16'h0000;
         end else if (cnt_run) begin
            runtime_cnt <= runtime_cnt + `DCWU_CNT_ONE;
         end
      end
   end

   // host response
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         resp <= '0;
         cmd_refused <= 1'b0;
      end else begin
         resp.valid <= 1'b0;
         cmd_refused <= cmd.valid && !cmd_ok;
         if (cmd_ok && cmd.code == `DCWU_CMD_REV) begin
            resp <= '{valid: 1'b1, data: {8'h00, REVISION}};
         end else if (cmd_ok && cmd.code == `DCWU_CMD_STAT) begin
            resp <= '{valid: 1'b1, data: {8'h00, status_byte}};
         end else if (cmd_ok && cmd.code == `DCWU_CMD_CNT) begin
            resp <= '{valid: 1'b1, data: runtime_cnt};
         end else if (cmd_ok && cmd.code == `DCWU_CMD_RCTL) begin
            resp <= '{valid: 1'b1, data: {8'h00, debug_control_reg}};
         end else if (core_ans.valid) begin
            resp <= core_ans;
         end
      end
   end

   // processor requests
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         core_req <= '0;
      end else begin
         core_req.valid <= 1'b0;
         if (cmd_ok && cmd.code >= `DCWU_CMD_WPC && cmd.code <= `DCWU_CMD_RREG) begin
            core_req.valid <= 1'b1;
            core_req.op <= dcwu_pkg::dcwu_op_t'(cmd.code[1:0] - 2'h2);
            core_req.addr <= cmd.arg;
            core_req.data <= cmd.data;
         end
      end
   end

   // watchpoint registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         watch_control_address_high <= `DCWU_WCTL_RST;
      end else begin
         if (apb_wr && paddr == `DCWU_OFF_WCTL) begin
            watch_control_address_high <= pwdata[7:0];
            watch_control_address_high[`DCWU_WCTL_RSVD] <= 1'b0;
         end
         if (read_protect_active) begin
            watch_control_address_high[`DCWU_WCTL_WR] <= 1'b0;
            watch_control_address_high[`DCWU_WCTL_RD] <= 1'b0;
            watch_control_address_high[`DCWU_WCTL_DM] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         watch_address_lo <= 8'h00;
         watch_data <= 8'h00;
      end else begin
         if (apb_wr && paddr == `DCWU_OFF_WADDR) begin
            watch_address_lo <= pwdata[7:0];
         end
         if (apb_wr && paddr == `DCWU_OFF_WDATA) begin
            watch_data <= pwdata[7:0];
         end
      end
   end

   // interrupt status, set wins over clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_status <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~w1c) | ev;
         irq <= |(irq_status & irq_mask);
         if (apb_wr && paddr == `DCWU_OFF_IMSK) begin
            irq_mask <= pwdata[`DCWU_EV_W-1:0];
         end
      end
   end

   // apb answer, one wait-free access phase
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apb_setup;
         if (apb_setup) begin
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            unique case (paddr)
               `DCWU_OFF_WCTL: prdata[7:0] <= watch_control_address_high;
               `DCWU_OFF_WADDR: prdata[7:0] <= watch_address_lo;
               `DCWU_OFF_WDATA: prdata[7:0] <= watch_data;
               `DCWU_OFF_CTL: prdata[7:0] <= debug_control_reg;
               `DCWU_OFF_STAT: prdata[7:0] <= status_byte;
               `DCWU_OFF_CNT: prdata[15:0] <= runtime_cnt;
               `DCWU_OFF_IST: prdata[`DCWU_EV_W-1:0] <= irq_status;
               `DCWU_OFF_IMSK: prdata[`DCWU_EV_W-1:0] <= irq_mask;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_rev_cmd;
      cmd.valid && cmd.code == `DCWU_CMD_REV;
   endsequence
   sequence s_rev_resp;
      resp.valid && resp.data == {8'h00, REVISION};
   endsequence
   sequence s_ignored;
      cmd_refused && !core_req.valid && !resp.valid;
   endsequence

   chk_rev_answer: assert property (s_rev_cmd |=> s_rev_resp)
      else $error("revision command not answered");
   chk_reserved_ignored: assert property (cmd.valid && cmd.code == `DCWU_CMD_RSVD |=> s_ignored)
      else $error("reserved command not ignored");
   chk_cnt_gate: assert property (cmd.valid && !debug_mode_flag && cmd.code == `DCWU_CMD_CNT |=> s_ignored)
      else $error("counter read answered outside debug mode");
   chk_rp_refuse: assert property (cmd.valid && read_protect_active && (cmd.code == `DCWU_CMD_WPC
      || cmd.code == `DCWU_CMD_RPC || cmd.code == `DCWU_CMD_RREG) |=> s_ignored)
      else $error("protected command not refused");
   chk_rp_wreg: assert property (cmd.valid && read_protect_active && cmd.code == `DCWU_CMD_WREG
      && !in_flash(cmd.arg[11:0]) |=> !core_req.valid)
      else $error("protected register write passed");
   chk_rp_keep_dbg: assert property (read_protect_active && debug_mode_flag && cmd.valid
      && cmd.code == `DCWU_CMD_WCTL |=> debug_mode_flag)
      else $error("debug mode cleared under protection");
   chk_watch_enter: assert property (watch_hit |=> debug_mode_flag && irq_status[`DCWU_EV_WATCH])
      else $error("watchpoint hit did not enter debug mode");
   chk_watch_enable: assert property (!debug_mode_flag && !(cmd.valid && cmd.code == `DCWU_CMD_WCTL)
      && !watch_control_address_high[`DCWU_WCTL_WR] && !watch_control_address_high[`DCWU_WCTL_RD]
      |=> !debug_mode_flag)
      else $error("watchpoint break with breaks disabled");
   chk_watch_data: assert property (!debug_mode_flag && !(cmd.valid && cmd.code == `DCWU_CMD_WCTL)
      && watch_control_address_high[`DCWU_WCTL_DM] && rf_acc.data != watch_data
      |=> !debug_mode_flag)
      else $error("data match ignored");
   chk_wctl_locked: assert property (read_protect_active |=> watch_control_address_high[7:5] == 3'h0)
      else $error("watch bits set under protection");
   chk_cnt_count: assert property (cnt_run |=> runtime_cnt == $past(runtime_cnt) + `DCWU_CNT_ONE)
      else $error("runtime counter did not advance");
   chk_cnt_hold: assert property (debug_mode_flag && dm_q |=> $stable(runtime_cnt))
      else $error("runtime counter moved in debug mode");
   chk_cnt_sat: assert property (runtime_cnt == `DCWU_CNT_MAX && !cnt_exit |=> runtime_cnt == `DCWU_CNT_MAX)
      else $error("runtime counter wrapped");
   chk_rp_status: assert property (rp_sync[2] == rp_sync[1] ##1 rp_sync[2] == rp_sync[1]
      |-> read_protect_active == ($past(rp_sync[2]) == `DCWU_RP_ON))
      else $error("protect status wrong");
   chk_write_break: assert property (rf_acc.wr && rf_acc.addr == watch_address
      && watch_control_address_high[`DCWU_WCTL_WR] && !watch_control_address_high[`DCWU_WCTL_DM]
      |=> debug_mode_flag)
      else $error("write watch missed");
   chk_read_break: assert property (rf_acc.rd && rf_acc.addr == watch_address
      && watch_control_address_high[`DCWU_WCTL_RD] && !watch_control_address_high[`DCWU_WCTL_DM]
      |=> debug_mode_flag)
      else $error("read watch missed");

endmodule : dcwu_top

// ---- tb/dcwu_host.sv ----
// debug host and processor answer model
`timescale 1ns/1ns
module dcwu_host #(
   parameter logic [15:0] CORE_DATA = 16'h00A5
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // command side
   output dcwu_pkg::dcwu_cmd_t cmd,
   input dcwu_pkg::dcwu_resp_t resp,
   input wire logic cmd_refused,
   // processor side
   input dcwu_pkg::dcwu_core_req_t core_req,
   output dcwu_pkg::dcwu_resp_t core_ans
);
   initial begin
      cmd = '0;
      core_ans = '0;
   end
   // processor answers a read one cycle after the request, idle data toggles
   always @(posedge ref_clk) begin
      core_ans.valid <= core_req.valid && (core_req.op inside {dcwu_pkg::op_rd_pc, dcwu_pkg::op_rd_reg});
      core_ans.data <= core_req.valid ? CORE_DATA : ~core_ans.data;
   end
   task automatic send(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d, output logic refd,
         output logic rv, output logic [15:0] rdv, output dcwu_pkg::dcwu_core_req_t req);
      @(posedge ref_clk);
      cmd <= '{1'b1, c, a, d};
      @(posedge ref_clk);
      cmd <= '{1'b0, ~c, ~a, ~d};
      #1;
      refd = cmd_refused;
      rv = resp.valid;
      rdv = resp.data;
      req = core_req;
      for (int i = 0; i < 3 && req.valid && !rv; i++) begin
         @(posedge ref_clk);
         #1;
         rv = resp.valid;
         rdv = resp.data;
      end
   endtask : send
endmodule : dcwu_host

// ---- tb/dcwu_top_test.sv ----
// self-checking bench of the debug command and watchpoint unit
`timescale 1ns/1ns
`include "dcwu_params.svh"
module dcwu_top_test;
   localparam logic [7:0] REV = 8'h3C;
   localparam logic [7:0] MASS = 8'hA5;
   logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, cmd_refused, rerr, refd, rv;
   logic read_protect_option, debug_mode_flag, read_protect_active, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat, keep;
   logic [15:0] rdv;
   int failures = 0;
   int check_count = 0;
   dcwu_pkg::dcwu_cmd_t cmd;
   dcwu_pkg::dcwu_resp_t resp, core_ans;
   dcwu_pkg::dcwu_rf_access_t rf_acc;
   dcwu_pkg::dcwu_core_req_t core_req, req;
   dcwu_top #(.REVISION(REV), .MASS_ERASE_CODE(MASS)) u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmd(cmd), .resp(resp), .cmd_refused(cmd_refused), .rf_acc(rf_acc),
      .core_ans(core_ans), .core_req(core_req), .read_protect_option(read_protect_option),
      .debug_mode_flag(debug_mode_flag), .read_protect_active(read_protect_active), .irq(irq));
   dcwu_host u_host (.ref_clk(ref_clk), .rst(rst), .cmd(cmd), .resp(resp), .cmd_refused(cmd_refused),
      .core_req(core_req), .core_ans(core_ans));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize;
      if (failures == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic hc(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
      u_host.send(c, a, d, refd, rv, rdv, req);
   endtask : hc
   task automatic rf(input logic r, input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      rf_acc <= '{r, w, a, d};
      @(posedge ref_clk);
      rf_acc <= '{1'b0, 1'b0, ~a, ~d};
      #1;
   endtask : rf
   task automatic t_idle;
      logic [9:0] refuse = 10'h3CA;
      for (int i = 0; i < 10; i++) begin
         hc(8'(i), 16'h0010, (i == 4) ? 8'h15 : 8'h00);
         check(refd, refuse[i]);
         check(rv, i == 0 || i == 2 || i == 5);
         check(req.valid, 1'b0);
         check(debug_mode_flag, 1'b0);
      end
      hc(`DCWU_CMD_REV, 16'h0000, 8'h00);
      check(rdv, {8'h00, REV});
      hc(`DCWU_CMD_RCTL, 16'h0000, 8'h00);
      check(rdv, 16'h0015);
   endtask : t_idle
   task automatic t_irq;
      apb(1'b1, `DCWU_OFF_IST, 32'h7);
      apb(1'b1, `DCWU_OFF_IMSK, 32'h0);
      hc(`DCWU_CMD_RSVD, 16'h0000, 8'h00);
      apb(1'b0, `DCWU_OFF_IST, 32'h0);
      check(rdat, 32'h2);
      check(irq, 1'b0);
      apb(1'b1, `DCWU_OFF_IMSK, 32'h2);
      repeat (2) @(posedge ref_clk);
      #1 check(irq, 1'b1);
      apb(1'b1, `DCWU_OFF_IST, 32'h2);
      repeat (2) @(posedge ref_clk);
      #1 check(irq, 1'b0);
      apb(1'b0, 8'h20, 32'h0);
      check(rerr, 1'b1);
   endtask : t_irq
   task automatic t_watch;
      apb(1'b1, `DCWU_OFF_IMSK, 32'h1);
      apb(1'b1, `DCWU_OFF_WADDR, 32'h34);
      apb(1'b1, `DCWU_OFF_WCTL, 32'h42);
      apb(1'b0, `DCWU_OFF_WCTL, 32'h0);
      check(rdat, 32'h42);
      rf(1'b0, 1'b1, 12'h234, 8'h00);
      check(debug_mode_flag, 1'b0);
      rf(1'b1, 1'b0, 12'h334, 8'h00);
      check(debug_mode_flag, 1'b0);
      rf(1'b1, 1'b0, 12'h234, 8'h00);
      check(debug_mode_flag, 1'b1);
      @(posedge ref_clk);
      #1 check(irq, 1'b1);
      apb(1'b1, `DCWU_OFF_IST, 32'h7);
      hc(`DCWU_CMD_WCTL, 16'h0000, 8'h00);
      apb(1'b1, `DCWU_OFF_WDATA, 32'h5A);
      apb(1'b1, `DCWU_OFF_WCTL, 32'hA2);
      check(debug_mode_flag, 1'b0);
      rf(1'b0, 1'b1, 12'h234, 8'h11);
      check(debug_mode_flag, 1'b0);
      rf(1'b1, 1'b0, 12'h234, 8'h5A);
      check(debug_mode_flag, 1'b0);
      rf(1'b0, 1'b1, 12'h234, 8'h5A);
      check(debug_mode_flag, 1'b1);
      hc(`DCWU_CMD_WCTL, 16'h0000, 8'h00);
      apb(1'b1, `DCWU_OFF_WCTL, 32'h22);
      rf(1'b1, 1'b1, 12'h234, 8'h5A);
      check(debug_mode_flag, 1'b0);
   endtask : t_watch
   task automatic t_count;
      apb(1'b0, `DCWU_OFF_CNT, 32'h0);
      keep = rdat;
      apb(1'b0, `DCWU_OFF_CNT, 32'h0);
      check(rdat, keep + 32'h3);
      hc(`DCWU_CMD_WCTL, 16'h0000, 8'h80);
      apb(1'b0, `DCWU_OFF_CNT, 32'h0);
      keep = rdat;
      apb(1'b0, `DCWU_OFF_CNT, 32'h0);
      check(rdat, keep);
      hc(`DCWU_CMD_CNT, 16'h0000, 8'h00);
      check(rdv, keep[15:0]);
   endtask : t_count
   task automatic t_dbg;
      hc(`DCWU_CMD_WPC, 16'h1234, 8'h00);
      check(req.valid, 1'b1);
      check(req.op, dcwu_pkg::op_wr_pc);
      check(req.addr, 16'h1234);
      hc(`DCWU_CMD_RREG, 16'h0010, 8'h00);
      check(req.op, dcwu_pkg::op_rd_reg);
      check(rdv, 16'h00A5);
      hc(`DCWU_CMD_WREG, 16'h0100, 8'h66);
      check(req.data, 8'h66);
      hc(`DCWU_CMD_RPC, 16'h0000, 8'h00);
      check(req.op, dcwu_pkg::op_rd_pc);
      check(rdv, 16'h00A5);
   endtask : t_dbg
   task automatic t_sat;
      hc(`DCWU_CMD_WCTL, 16'h0000, 8'h00);
      check(debug_mode_flag, 1'b0);
      repeat (65600) @(posedge ref_clk);
      apb(1'b0, `DCWU_OFF_CNT, 32'h0);
      check(rdat, 32'h0000_FFFF);
      apb(1'b0, `DCWU_OFF_IST, 32'h0);
      check(rdat[`DCWU_EV_FULL], 1'b1);
      hc(`DCWU_CMD_WCTL, 16'h0000, 8'h80);
      check(debug_mode_flag, 1'b1);
   endtask : t_sat
   task automatic t_prot;
      logic [7:0] bad [3] = '{`DCWU_CMD_WPC, `DCWU_CMD_RPC, `DCWU_CMD_RREG};
      @(posedge ref_clk);
      read_protect_option <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1 check(read_protect_active, 1'b1);
      apb(1'b0, `DCWU_OFF_STAT, 32'h0);
      check(rdat[7:0], 8'h81);
      hc(`DCWU_CMD_STAT, 16'h0000, 8'h00);
      check(rdv, 16'h0081);
      foreach (bad[i]) begin
         hc(bad[i], 16'h0010, 8'h00);
         check(refd, 1'b1);
      end
      hc(`DCWU_CMD_WREG, 16'h0100, MASS);
      check(refd, 1'b1);
      hc(`DCWU_CMD_WREG, 16'h0FF8, 8'h01);
      check(refd, 1'b1);
      hc(`DCWU_CMD_WREG, 16'h0FF8, MASS);
      check(req.valid, 1'b1);
      hc(`DCWU_CMD_WREG, 16'h0FF9, 8'h33);
      check(req.valid, 1'b1);
      hc(`DCWU_CMD_WCTL, 16'h0000, 8'h00);
      apb(1'b1, `DCWU_OFF_WCTL, 32'hE5);
      check(debug_mode_flag, 1'b1);
      apb(1'b0, `DCWU_OFF_WCTL, 32'h0);
      check(rdat, 32'h05);
   endtask : t_prot
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #800000;
      failures++;
      summarize;
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      rf_acc = '0;
      read_protect_option = 1'b1;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1 check(read_protect_active, 1'b0);
      apb(1'b0, `DCWU_OFF_WCTL, 32'h0);
      check(rdat, 32'h0);
      t_idle;
      t_irq;
      t_watch;
      t_count;
      t_dbg;
      t_sat;
      t_prot;
      summarize;
   end
endmodule : dcwu_top_test
